// [hw/branch_skip_pkg.sv]
/*
  Package for the branch and skip decision block: opcodes, flag
  positions, carrier structs and cycle counts.
  Assumes a 22-bit word program counter and an 8-bit status byte.
*/
package branch_skip_pkg;
  localparam int PC_W = 22;
  localparam int K_W  = 7;

  // status byte bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // cycle counts
  localparam logic [2:0] CYC_BR_NOT   = 3'h1;
  localparam logic [2:0] CYC_BR_TAKEN = 3'h2;
  localparam logic [2:0] CYC_REG_SKIP = 3'h1;
  localparam logic [2:0] CYC_IO_SKIP  = 3'h2;
  localparam logic [2:0] CYC_SKIP_ONE = 3'h1;
  localparam logic [2:0] CYC_SKIP_TWO = 3'h2;
  localparam logic [2:0] CYC_RESET    = 3'h0;

  localparam logic [PC_W-1:0] PC_STEP1 = 22'h000001;
  localparam logic [PC_W-1:0] PC_STEP2 = 22'h000002;
  localparam logic [PC_W-1:0] PC_STEP3 = 22'h000003;
  localparam logic [PC_W-1:0] PC_RESET = 22'h000000;

  typedef enum logic [4:0] {
    skip_reg_bit_clear, skip_reg_bit_set,
    skip_io_bit_clear, skip_io_bit_set,
    branch_flag_set, branch_flag_clear,
    branch_if_equal, branch_if_not_equal,
    branch_carry_set, branch_carry_clear,
    branch_same_or_higher, branch_unsigned_lower,
    branch_if_minus, branch_if_plus,
    branch_signed_ge, branch_signed_lt,
    branch_half_carry_set, branch_half_carry_clear,
    branch_transfer_bit_set, branch_transfer_bit_clear,
    branch_overflow_set, branch_overflow_clear,
    branch_irq_enabled, branch_irq_disabled
  } op_t;

  typedef struct packed {
    op_t             op;
    logic [2:0]      sel;      // s for flag branches, b for skips
    logic [K_W-1:0]  k;
    logic [7:0]      operand;  // register or i/o byte under test
    logic            next_two_word;
  } request_t;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic            taken;
    logic [2:0]      cycles;
  } result_t;
endpackage

// [hw/branch_skip_control.sv]
/*
  Branch and skip decision block: takes one instruction per valid strobe,
  evaluates its condition and answers with the new program counter,
  taken flag and cycle count one clock later.
  Assumes requests come from core logic on clk_in; status flags are only
  read here, never written.
*/
// Behaviour
// [RULE1] reg bit clear skip: skip next instruction on bit b 0, 1/2/3 cycles.
// [RULE2] reg bit set skip: skip next instruction on bit b 1, 1/2/3 cycles.
// [RULE3] i/o bit clear skip: skip next instruction on bit b 0, 2/3/4 cycles.
// [RULE4] i/o bit set skip: skip next instruction on bit b 1, 2/3/4 cycles.
// [RULE5] flag set branch goes to pc+k+1 when status bit s is 1, 1 or 2 cycles.
// [RULE6] flag clear branch goes to pc+k+1 when status bit s is 0, 1 or 2 cyc.
// [RULE7] equal branches on z 1, not-equal on z 0, 1 or 2 cycles.
// [RULE8] carry set/lower branch on c 1, carry clear/same-or-higher on c 0.
// [RULE9] minus branches on n 1 and plus on n 0, 1 or 2 cycles.
// [RULE10] signed ge branches when n xor v is 0, signed lt when it is 1.
// [RULE11] half-carry set and clear branches test h for 1 and 0.
// [RULE12] transfer-bit set and clear branches test t for 1 and 0.
// [RULE13] overflow set and clear branches test v, target pc+k+1.
// [RULE14] irq enabled and disabled branches test the global enable bit.
// [RULE15] a taken skip steps pc by 2 past one word, by 3 past two words.
// [RULE16] k is sign-extended two's complement before it is added to pc+1.
`timescale 1ns/1ps
`default_nettype none
module branch_skip_control
  import branch_skip_pkg::*;
(
  input  wire logic            clk_in,
  input  wire logic            rstn_in,
  input  wire logic            valid_in,
  input  wire request_t        req_in,
  input  wire logic [PC_W-1:0] pc_in,
  input  wire logic [7:0]      flags_in,
  output var  result_t         result_out,
  output var  logic            done_out
);
  // instruction class, shared by the pc and cycle paths
  typedef enum logic [1:0] {
    class_reg_skip,
    class_io_skip,
    class_branch,
    class_undefined
  } op_class_t;

  op_class_t       op_class;
  logic            bit_sel;
  logic            flag_sel;
  logic            flag_carry;
  logic            flag_zero;
  logic            flag_neg;
  logic            flag_ovf;
  logic            flag_half;
  logic            flag_xfer;
  logic            flag_irq;
  logic            sign_lt;
  logic            cond;
  logic [PC_W-1:0] k_ext;
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] pc_skip;
  logic [PC_W-1:0] pc_branch;
  logic [2:0]      skip_base;
  logic [2:0]      skip_extra;
  logic [PC_W-1:0] next_pc;
  logic            next_taken;
  logic [2:0]      next_cycles;
  logic [PC_W-1:0] result_pc;
  logic            result_taken;
  logic [2:0]      result_cycles;

  // operand bit under test for the four skips
  assign bit_sel  = req_in.operand[req_in.sel];
  // status bit picked by s for the generic flag branches
  assign flag_sel = flags_in[req_in.sel];

  assign flag_carry = flags_in[FLAG_C];
  assign flag_zero  = flags_in[FLAG_Z];
  assign flag_neg   = flags_in[FLAG_N];
  assign flag_ovf   = flags_in[FLAG_V];
  assign flag_half  = flags_in[FLAG_H];
  assign flag_xfer  = flags_in[FLAG_T];
  assign flag_irq   = flags_in[FLAG_I];
  // recomputed from n and v, the stored s bit may lag a flag write
  assign sign_lt    = flag_neg ^ flag_ovf; // [RULE10]
  assign k_ext      = PC_W'($signed(req_in.k)); // [RULE16]
  assign pc_inc     = pc_in + PC_STEP1;

  always_comb begin
    unique case (req_in.op)
      skip_reg_bit_clear,
      skip_reg_bit_set: begin
        op_class = class_reg_skip;
      end
      skip_io_bit_clear,
      skip_io_bit_set: begin
        op_class = class_io_skip;
      end
      branch_flag_set,
      branch_flag_clear,
      branch_if_equal,
      branch_if_not_equal,
      branch_carry_set,
      branch_carry_clear,
      branch_same_or_higher,
      branch_unsigned_lower,
      branch_if_minus,
      branch_if_plus,
      branch_signed_ge,
      branch_signed_lt,
      branch_half_carry_set,
      branch_half_carry_clear,
      branch_transfer_bit_set,
      branch_transfer_bit_clear,
      branch_overflow_set,
      branch_overflow_clear,
      branch_irq_enabled,
      branch_irq_disabled: begin
        op_class = class_branch;
      end
      // codes past the last branch are not instructions of this block
      default: begin
        op_class = class_undefined;
      end
    endcase
  end

  always_comb begin
    unique case (req_in.op)
      skip_reg_bit_clear:        cond = ~bit_sel; // [RULE1]
      skip_reg_bit_set:          cond = bit_sel; // [RULE2]
      skip_io_bit_clear:         cond = ~bit_sel; // [RULE3]
      skip_io_bit_set:           cond = bit_sel; // [RULE4]
      branch_flag_set:           cond = flag_sel; // [RULE5]
      branch_flag_clear:         cond = ~flag_sel; // [RULE6]
      branch_if_equal:           cond = flag_zero; // [RULE7]
      branch_if_not_equal:       cond = ~flag_zero; // [RULE7]
      branch_carry_set:          cond = flag_carry; // [RULE8]
      branch_unsigned_lower:     cond = flag_carry; // [RULE8]
      branch_carry_clear:        cond = ~flag_carry; // [RULE8]
      branch_same_or_higher:     cond = ~flag_carry; // [RULE8]
      branch_if_minus:           cond = flag_neg; // [RULE9]
      branch_if_plus:            cond = ~flag_neg; // [RULE9]
      branch_signed_ge:          cond = ~sign_lt; // [RULE10]
      branch_signed_lt:          cond = sign_lt; // [RULE10]
      branch_half_carry_set:     cond = flag_half; // [RULE11]
      branch_half_carry_clear:   cond = ~flag_half; // [RULE11]
      branch_transfer_bit_set:   cond = flag_xfer; // [RULE12]
      branch_transfer_bit_clear: cond = ~flag_xfer; // [RULE12]
      branch_overflow_set:       cond = flag_ovf; // [RULE13]
      branch_overflow_clear:     cond = ~flag_ovf; // [RULE13]
      branch_irq_enabled:        cond = flag_irq; // [RULE14]
      branch_irq_disabled:       cond = ~flag_irq; // [RULE14]
      default:                   cond = 1'b0;
    endcase
  end

  // skip target lies past one or two words of the skipped instruction
  always_comb begin
    if (req_in.next_two_word) begin
      pc_skip = pc_in + PC_STEP3; // [RULE15]
    end else begin
      pc_skip = pc_in + PC_STEP2; // [RULE15]
    end
  end

  assign pc_branch = pc_inc + k_ext; // [RULE16]

  always_comb begin
    if (op_class == class_io_skip) begin
      // i/o skips pay one extra cycle for the i/o read
      skip_base = CYC_IO_SKIP; // [RULE3]
    end else begin
      skip_base = CYC_REG_SKIP; // [RULE1]
    end
  end

  always_comb begin
    if (req_in.next_two_word) begin
      skip_extra = CYC_SKIP_TWO; // [RULE15]
    end else begin
      skip_extra = CYC_SKIP_ONE; // [RULE15]
    end
  end

  always_comb begin
    next_taken = cond;
    unique case (op_class)
      class_reg_skip,
      class_io_skip: begin
        if (cond) begin
          next_pc     = pc_skip;
          next_cycles = skip_base + skip_extra;
        end else begin
          next_pc     = pc_inc;
          next_cycles = skip_base;
        end
      end
      class_branch: begin
        if (cond) begin
          next_pc     = pc_branch; // [RULE5]
          next_cycles = CYC_BR_TAKEN;
        end else begin
          next_pc     = pc_inc;
          next_cycles = CYC_BR_NOT;
        end
      end
      class_undefined: begin
        // unknown codes retire as a plain not-taken branch
        next_pc     = pc_inc;
        next_cycles = CYC_BR_NOT;
      end
    endcase
  end

  // result fields hold until the next accepted request
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      result_pc <= PC_RESET;
    end else if (valid_in) begin
      result_pc <= next_pc;
    end
  end

  // flags are only read here, never written
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      result_taken <= 1'b0;
    end else if (valid_in) begin
      result_taken <= next_taken;
    end
  end

  // cycles are reported only; the core does its own stalling
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      result_cycles <= CYC_RESET;
    end else if (valid_in) begin
      result_cycles <= next_cycles;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= valid_in;
    end
  end

  // plain wiring from the registers, no logic on the way out
  assign result_out = '{
    pc:     result_pc,
    taken:  result_taken,
    cycles: result_cycles
  };
endmodule
`default_nettype wire

// [tb/branch_skip_monitor.sv]
/* port checker for branch_skip_control
   assumes one clock domain, reset active low */
`timescale 1ns/1ps
`default_nettype none
module branch_skip_monitor
  import branch_skip_pkg::*;
(
  input wire logic            clk_in,
  input wire logic            rstn_in,
  input wire logic            valid_in,
  input wire request_t        req_in,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [7:0]      flags_in,
  input wire result_t         result_out,
  input wire logic            done_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  wire br = valid_in && req_in.op >= branch_flag_set;
  wire sk = valid_in && req_in.op <= skip_io_bit_set;
  wire [2:0] sk_base = (req_in.op == skip_io_bit_clear ||
    req_in.op == skip_io_bit_set) ? CYC_IO_SKIP : CYC_REG_SKIP;
  sequence s_ans; ##1 done_out; endsequence
  property p_done; valid_in |-> s_ans; endproperty
  property p_idle; !valid_in |=> !done_out && $stable(result_out); endproperty
  property p_brcyc; br |=> result_out.cycles ==
    (result_out.taken ? CYC_BR_TAKEN : CYC_BR_NOT); endproperty
  property p_notk; valid_in |=> result_out.taken ||
    result_out.pc == $past(pc_in) + PC_STEP1; endproperty
  property p_eq; valid_in && req_in.op == branch_if_equal |=>
    result_out.taken == $past(flags_in[FLAG_Z]); endproperty
  property p_ge; valid_in && req_in.op == branch_signed_ge |=>
    result_out.taken == !$past(flags_in[FLAG_N] ^ flags_in[FLAG_V]);
  endproperty
  property p_skpc; sk |=> !result_out.taken || result_out.pc == $past(pc_in)
    + ($past(req_in.next_two_word) ? PC_STEP3 : PC_STEP2); endproperty
  property p_brpc; br |=> !result_out.taken || result_out.pc == $past(pc_in)
    + PC_STEP1 + {{(PC_W-K_W){$past(req_in.k[K_W-1])}}, $past(req_in.k)};
  endproperty
  property p_skset; valid_in && (req_in.op == skip_reg_bit_set ||
    req_in.op == skip_io_bit_set) |=>
    result_out.taken == $past(req_in.operand[req_in.sel]); endproperty
  property p_skcyc; sk |=> result_out.cycles == $past(sk_base) +
    (!result_out.taken ? 3'h0 : $past(req_in.next_two_word) ?
    CYC_SKIP_TWO : CYC_SKIP_ONE); endproperty
  a_done: assert property (p_done) else $error("no done");
  a_idle: assert property (p_idle) else $error("idle change");
  a_brcyc: assert property (p_brcyc) else $error("branch cycles");
  a_notk: assert property (p_notk) else $error("not taken pc");
  a_eq: assert property (p_eq) else $error("equal branch");
  a_ge: assert property (p_ge) else $error("signed ge");
  a_skpc: assert property (p_skpc) else $error("skip pc");
  a_brpc: assert property (p_brpc) else $error("branch target");
  a_skset: assert property (p_skset) else $error("skip set");
  a_skcyc: assert property (p_skcyc) else $error("skip cycles");
endmodule
bind branch_skip_control branch_skip_monitor u_mon (.clk_in(clk_in),
  .rstn_in(rstn_in), .valid_in(valid_in), .req_in(req_in), .pc_in(pc_in),
  .flags_in(flags_in), .result_out(result_out), .done_out(done_out));
`default_nettype wire

// [tb/tb_top.sv]
/* random self-checking bench for branch_skip_control
   drives all ports itself, one clock at 250 MHz */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import branch_skip_pkg::*;
  logic            clk_in   = 1'b0;
  logic            rstn_in  = 1'b0;
  logic            valid_in = 1'b0;
  logic            done_out;
  logic            exp_d;
  request_t        req_in   = '0;
  logic [PC_W-1:0] pc_in    = '0;
  logic [7:0]      flags_in = '0;
  result_t         result_out;
  result_t         exp_r;
  result_t         exp_q [$];
  logic [63:0]     v;
  logic [31:0]     seed     = 32'h0000d8d6;
  int              fail_count;
  int              n_checks;
  // flag tested by each pair of condition codes, indexed by code / 2
  localparam int   idx [12] = '{FLAG_C, FLAG_C, FLAG_C, FLAG_Z, FLAG_C,
    FLAG_C, FLAG_N, FLAG_C, FLAG_H, FLAG_T, FLAG_V, FLAG_I};
  always #2 clk_in = ~clk_in;
  branch_skip_control DUT (.clk_in(clk_in), .rstn_in(rstn_in),
    .valid_in(valid_in), .req_in(req_in), .pc_in(pc_in),
    .flags_in(flags_in), .result_out(result_out), .done_out(done_out));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic result_t model(request_t r, logic [PC_W-1:0] pc,
                                    logic [7:0] f);
    int              o;
    logic            c;
    logic [PC_W-1:0] k;
    result_t         e;
    o = r.op;
    k = {{(PC_W-K_W){r.k[K_W-1]}}, r.k};
    if (o < 4) begin
      c = r.operand[r.sel] ^ !o[0];
    end else if (o < 6) begin
      c = f[r.sel] ^ o[0];
    end else if (o < 24) begin
      // signed pair reads n xor v, never the stored s bit
      c = (o / 2 == 7 ? f[FLAG_N] ^ f[FLAG_V] : f[idx[o / 2]]) ^ o[0] ^
          (o inside {10, 11, 14, 15});
    end else begin
      c = 1'b0;
    end
    e.taken = c;
    if (o < 4) begin
      e.pc = pc + (c ? 22'h2 + r.next_two_word : 22'h1);
      e.cycles = 3'(1 + o / 2 + (c ? 1 + r.next_two_word : 0));
    end else begin
      e.pc = pc + (c ? k + 22'h1 : 22'h1);
      e.cycles = c ? 3'h2 : 3'h1;
    end
    return e;
  endfunction
  task automatic check(logic d, result_t e);
    n_checks++;
    if (done_out !== d) begin
      fail_count++;
      $display("Error done_out exp %b seen %b", d, done_out);
    end
    if (result_out !== e) begin
      fail_count++;
      $display("Error result_out exp %h seen %h", e, result_out);
    end
  endtask
  // random requests over every code incl. undefined ones, gaps mixed in
  task automatic run_stream(int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      #1;
      if (exp_d) exp_r = exp_q.pop_front();
      check(exp_d, exp_r);
      v = {rnd(), rnd()};
      req_in = v[23:0];
      req_in.op = op_t'(5'(i));
      pc_in = v[45:24];
      flags_in = v[53:46];
      valid_in = v[55:54] != 2'h0;
      exp_d = valid_in;
      if (valid_in) exp_q.push_back(model(req_in, pc_in, flags_in));
    end
  endtask
  // collects the answer to the last request and leaves the strobe low
  task automatic drain();
    @(posedge clk_in);
    #1;
    if (exp_d) exp_r = exp_q.pop_front();
    check(exp_d, exp_r);
    valid_in = 1'b0;
    exp_d = 1'b0;
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    exp_d = 1'b0;
    exp_r = '0;
    repeat (12) @(posedge clk_in);
    #1 rstn_in = 1'b1;
    run_stream(1600);
    drain();
    $display("random stream done");
    // second reset in mid-run clears the outputs with no clock edge
    rstn_in = 1'b0;
    #1 check(1'b0, '0);
    exp_r = '0;
    repeat (3) @(posedge clk_in);
    #1 rstn_in = 1'b1;
    run_stream(400);
    drain();
    $display("mid-run reset done");
    complete_run();
  end
endmodule
`default_nettype wire
